// [rtl/spiqk_master.sv]
// Serial peripheral master with per-select configuration and its known quirks
`timescale 1ns/10ps
module spiqk_master
    import spiqk_pkg::*;
#(
    parameter int NSEL = SPIQK_NSEL
)
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic controller_role_bit,
    input wire logic fixed_select_mode,
    input wire logic [$clog2(NSEL)-1:0] fixed_select,
    input wire logic cfg_wr,
    input wire logic [$clog2(NSEL)-1:0] cfg_sel,
    input wire logic [SPIQK_DIV_W-1:0] cfg_serial_clock_divider,
    input wire logic [SPIQK_LEN_W-1:0] cfg_word_len,
    input wire logic cfg_cpol,
    input wire logic cfg_clock_phase_inverse,
    input wire logic cfg_cs_hold_after_transfer,
    input wire logic tx_valid,
    input wire logic [31:0] transmit_data_word,
    input wire logic tx_from_dma,
    input wire logic miso,
    output logic tx_ready,
    output logic transmit_drained_flag,
    output logic rx_valid,
    output logic [15:0] rx_data,
    output logic dma_size,
    output logic serial_clock_pin,
    output logic mosi,
    output logic [NSEL-1:0] cs_n
);
    localparam int SW = $clog2(NSEL);
    // ****************************************
    // Decoding helpers
    // ****************************************
    function automatic logic [4:0] word_len(input logic [SPIQK_LEN_W-1:0] code);
        word_len = SPIQK_LEN_BASE + {1'b0, code};
    endfunction

    function automatic logic [SW-1:0] pcs_sel(input logic [NSEL-1:0] pcs);
        pcs_sel = '0;
        for (int i = NSEL - 1; i >= 0; i--)
        begin
            if (!pcs[i])
                pcs_sel = SW'(i);
        end
    endfunction
    // ****************************************
    // Per-select configuration bank
    // ****************************************
    logic [SPIQK_DIV_W-1:0] div_cfg [NSEL];
    logic [SPIQK_LEN_W-1:0] len_cfg [NSEL];
    logic [NSEL-1:0] cpol_cfg, clock_phase_inverse_cfg, hold_cfg;
    genvar g;
    generate
        for (g = 0; g < NSEL; g++)
        begin : g_cfg
            // One configuration word per select
            always_ff @(posedge core_clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    div_cfg[g] <= SPIQK_DIV_RST;
                    len_cfg[g] <= SPIQK_LEN_RST;
                    cpol_cfg[g] <= 1'b0;
                    clock_phase_inverse_cfg[g] <= 1'b0;
                    hold_cfg[g] <= 1'b0;
                end
                else if (cfg_wr && cfg_sel == SW'(g))
                begin
                    div_cfg[g] <= cfg_serial_clock_divider;
                    len_cfg[g] <= cfg_word_len;
                    cpol_cfg[g] <= cfg_cpol;
                    clock_phase_inverse_cfg[g] <= cfg_clock_phase_inverse;
                    hold_cfg[g] <= cfg_cs_hold_after_transfer;
                end
            end
        end
    endgenerate
    // ****************************************
    // State
    // ****************************************
    spiqk_state_t state;
    logic [31:0] hold_word;
    logic [SW-1:0] cur_sel, held_sel;
    logic [SPIQK_EDGE_W-1:0] edge_cnt, cur_total;
    logic [4:0] cur_len;
    logic [15:0] shift_tx, shift_rx;
    logic [1:0] stray_cnt;
    logic hold_valid, cur_final, cur_extra, cs_held, idle_gap, prev_div_one, tick;
    // ****************************************
    // Next-transfer decode
    // ****************************************
    wire [SW-1:0] next_sel = fixed_select_mode ? fixed_select : pcs_sel(hold_word[SPIQK_TDW_PCS_LO +: NSEL]);
    wire next_div_one = (div_cfg[next_sel] == SPIQK_DIV_ONE);
    wire [4:0] next_len = word_len(len_cfg[next_sel]);
    wire next_odd = next_len[0];
    wire next_pol_mode = cpol_cfg[next_sel] && !clock_phase_inverse_cfg[next_sel];
    // Extra pulse on odd length at divider 1, or slow-then-fast select with idle-high clock and no phase inverse
    wire next_extra = next_div_one && (next_odd || (next_pol_mode && !prev_div_one));
    wire [SPIQK_EDGE_W-1:0] next_total = SPIQK_EDGE_W'({next_len, 1'b0}) + (next_extra ? SPIQK_EXTRA_EDGES : '0);
    // Ready is not restored when a held select restarts after a gap at divider 1
    wire ready_quirk = hold_cfg[next_sel] && next_div_one && idle_gap && cs_held && held_sel == next_sel;
    wire start = controller_role_bit && hold_valid && state == SPIQK_IDLE; // Word end is reported first
    wire take = tx_valid && tx_ready;
    wire cap_edge = edge_cnt[0] ^ clock_phase_inverse_cfg[cur_sel];
    wire data_edge = edge_cnt < SPIQK_EDGE_W'({cur_len, 1'b0});
    wire last_edge = tick && (edge_cnt == cur_total - 1'b1);
    // Select is kept only while hold is on and the word did not end the frame
    wire release_cs = !hold_cfg[cur_sel] || cur_final;
    wire [4:0] size_len = word_len(fixed_select_mode ? len_cfg[0] : len_cfg[cur_sel]);
    wire [NSEL-1:0] sel_mask = NSEL'(1) << cur_sel;
    spiqk_tick u_tick (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .run(state == SPIQK_SHIFT),
        .divider(div_cfg[cur_sel]),
        .tick(tick)
    );
    // ****************************************
    // Holding register and ready flag
    // ****************************************
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hold_word <= '0;
            hold_valid <= 1'b0;
            tx_ready <= 1'b1;
        end
        else if (take)
        begin
            hold_word <= transmit_data_word;
            hold_valid <= 1'b1;
            tx_ready <= 1'b0;
        end
        else if (start)
        begin
            hold_valid <= ready_quirk;
            tx_ready <= !ready_quirk;
        end
    end
    // ****************************************
    // Transfer sequencer, shifter and select lines
    // ****************************************
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= SPIQK_IDLE;
            cur_sel <= '0;
            cur_final <= 1'b0;
            cur_extra <= 1'b0;
            cur_len <= SPIQK_LEN_BASE;
            cur_total <= '0;
            edge_cnt <= '0;
            shift_tx <= '0;
            shift_rx <= '0;
            cs_n <= '1;
            cs_held <= 1'b0;
            held_sel <= '0;
            idle_gap <= 1'b0;
            prev_div_one <= 1'b1;
            transmit_drained_flag <= 1'b1;
            rx_valid <= 1'b0;
            rx_data <= '0;
            mosi <= 1'b0;
        end
        else
        begin
            rx_valid <= 1'b0;
            if (start)
            begin
                state <= SPIQK_SHIFT;
                cur_sel <= next_sel;
                cur_final <= hold_word[SPIQK_TDW_FINAL] && tx_from_dma;
                cur_extra <= next_extra;
                cur_len <= next_len;
                cur_total <= next_total;
                edge_cnt <= '0;
                shift_tx <= hold_word[SPIQK_TDW_DATA_HI:0] << (SPIQK_LEN_FULL - next_len);
                mosi <= hold_word[4'(next_len - 1'b1)];
                shift_rx <= '0;
                cs_n <= ~(NSEL'(1) << next_sel);
                idle_gap <= 1'b0;
                prev_div_one <= next_div_one;
                transmit_drained_flag <= 1'b0;
            end
            else if (state == SPIQK_SHIFT)
            begin
                if (tick)
                    edge_cnt <= edge_cnt + 1'b1;
                if (tick && data_edge && cap_edge)
                    shift_rx <= {shift_rx[14:0], miso};
                if (tick && data_edge && !cap_edge && edge_cnt != '0)
                begin
                    shift_tx <= shift_tx << 1;
                    mosi <= shift_tx[14];
                end
                if (last_edge)
                    state <= SPIQK_DONE;
            end
            else if (state == SPIQK_DONE)
            begin
                state <= SPIQK_IDLE;
                rx_valid <= 1'b1;
                rx_data <= shift_rx;
                transmit_drained_flag <= 1'b1;
                // Drained and final flag end the frame together
                cs_n <= release_cs ? '1 : ~sel_mask;
                cs_held <= !release_cs;
                held_sel <= cur_sel;
                idle_gap <= 1'b0;
            end
            else if (!controller_role_bit)
            begin
                cs_n <= '1;
                cs_held <= 1'b0;
            end
            else
                idle_gap <= cs_held; // Held select idles with nothing queued
        end
    end
    // ****************************************
    // Serial clock pin, including stray toggles
    // ****************************************
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            serial_clock_pin <= 1'b0;
            stray_cnt <= '0;
            dma_size <= SPIQK_SIZE_BYTE;
        end
        else
        begin
            dma_size <= (size_len == SPIQK_LEN_BASE) ? SPIQK_SIZE_BYTE : SPIQK_SIZE_HALF;
            if (cfg_wr && !controller_role_bit)
                stray_cnt <= SPIQK_STRAY_TOGGLES;
            else if (state == SPIQK_IDLE && controller_role_bit && stray_cnt != '0)
            begin
                stray_cnt <= stray_cnt - 1'b1;
                serial_clock_pin <= ~serial_clock_pin;
            end
            else if (state == SPIQK_SHIFT && tick)
                serial_clock_pin <= ~serial_clock_pin;
            else if (state == SPIQK_IDLE && stray_cnt == '0)
                serial_clock_pin <= cpol_cfg[next_sel]; // Idle level of the select about to run
        end
    end
    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    chk_ready_quirk: assert property (start && !take && ready_quirk |=> !tx_ready && hold_valid)
        else $error("ready rose despite held-select restart at divider one");
    chk_ready_normal: assert property (start && !take && !ready_quirk |=> tx_ready && !hold_valid)
        else $error("ready not restored after shifter load");
    chk_final_release: assert property ($rose(transmit_drained_flag) && $past(cur_final) |-> cs_n == '1)
        else $error("select held after final word drained");
    chk_stray_toggle: assert property (state == SPIQK_IDLE && controller_role_bit && stray_cnt != '0 && !cfg_wr
        |=> $changed(serial_clock_pin))
        else $error("no early clock toggle after config before role");
    chk_dma_size: assert property (fixed_select_mode && $stable(len_cfg[0]) && $stable(fixed_select_mode)
        |=> dma_size == ($past(len_cfg[0]) != SPIQK_LEN_8BIT))
        else $error("dma size not taken from select zero");
    chk_odd_extra: assert property (start && next_div_one && next_odd
        |=> cur_total == SPIQK_EDGE_W'({cur_len, 1'b0}) + SPIQK_EXTRA_EDGES)
        else $error("odd length at divider one lacks extra pulse");
    chk_mix_extra: assert property (start && next_div_one && next_pol_mode && !prev_div_one |=> cur_extra)
        else $error("slow then fast select lacks extra pulse");
    chk_even_clean: assert property (start && !next_odd && (!next_pol_mode || prev_div_one) |=> !cur_extra)
        else $error("unexpected extra pulse");
    chk_cs_onehot: assert property ($onehot0(~cs_n))
        else $error("more than one select asserted");
    chk_done_pulse: assert property (last_edge |=> state == SPIQK_DONE ##1 rx_valid && transmit_drained_flag)
        else $error("transfer end not reported");
    cov_held_restart: cover property (start && ready_quirk);
    cov_final_dma: cover property (state == SPIQK_DONE && cur_final && hold_cfg[cur_sel]);
    cov_extra: cover property (start && next_extra);
    cov_stray: cover property (stray_cnt != '0 ##1 stray_cnt == '0);
endmodule

// [rtl/spiqk_pkg.sv]
// Shared constants and types for the serial peripheral master
package spiqk_pkg;

    // ****************************************
    // Geometry
    // ****************************************
    localparam int SPIQK_NSEL = 4;
    localparam int SPIQK_DIV_W = 8;
    localparam int SPIQK_LEN_W = 4;
    localparam int SPIQK_EDGE_W = 6;

    // ****************************************
    // Transmit word layout
    // ****************************************
    localparam int SPIQK_TDW_FINAL = 24;
    localparam int SPIQK_TDW_PCS_LO = 16;
    localparam int SPIQK_TDW_DATA_HI = 15;

    // ****************************************
    // Field values and reset values
    // ****************************************
    localparam logic [SPIQK_DIV_W-1:0] SPIQK_DIV_ONE = 8'h01;
    localparam logic [SPIQK_DIV_W-1:0] SPIQK_DIV_RST = 8'h01;
    localparam logic [SPIQK_LEN_W-1:0] SPIQK_LEN_8BIT = 4'h0;
    localparam logic [SPIQK_LEN_W-1:0] SPIQK_LEN_RST = 4'h0;
    localparam logic [4:0] SPIQK_LEN_BASE = 5'h08;
    localparam logic [4:0] SPIQK_LEN_FULL = 5'h10;
    localparam logic [SPIQK_EDGE_W-1:0] SPIQK_EXTRA_EDGES = 6'h02;
    localparam logic [1:0] SPIQK_STRAY_TOGGLES = 2'h2;
    localparam logic SPIQK_SIZE_BYTE = 1'b0;
    localparam logic SPIQK_SIZE_HALF = 1'b1;

    // ****************************************
    // Transfer sequencer states, Gray from idle to done, two bits change on the way back to idle
    // ****************************************
    typedef enum logic [1:0] {
        SPIQK_IDLE = 2'h0,
        SPIQK_SHIFT = 2'h1,
        SPIQK_DONE = 2'h3
    } spiqk_state_t;

endpackage

// [rtl/spiqk_tick.sv]
// Serial clock half-period tick generator
`timescale 1ns/10ps
module spiqk_tick
    import spiqk_pkg::*;
#(
    parameter int DIV_W = SPIQK_DIV_W
)
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic run,
    input wire logic [DIV_W-1:0] divider,
    output logic tick
);

    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] div_last;
    logic at_end;

    // A divider of zero behaves as one
    assign div_last = (divider == '0) ? '0 : divider - 1'b1;
    assign at_end = (cnt >= div_last);

    // Count system clocks per serial clock half period
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt <= '0;
            tick <= 1'b0;
        end
        else
        begin
            cnt <= (!run || at_end) ? '0 : cnt + 1'b1;
            tick <= run && at_end;
        end
    end

endmodule

// [tb/spiqk_master_test.sv]
// Self-checking bench for the serial peripheral master
`timescale 1ns/10ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin fail_count++; $display("BAD %s exp %0h got %0h", nm, e, s); end end
module spiqk_master_test
    import spiqk_pkg::*;
;
    logic core_clk, arst_n, role, fmode, cfg_wr, cp, ph, hold, tx_valid, dma, miso, lvl, clr;
    logic [1:0] fsel, csel;
    logic [7:0] div;
    logic [3:0] wlen;
    logic [31:0] word;
    logic tx_ready, drained, rx_valid, dma_size, sclk, mosi, first_bit;
    logic [15:0] rx_data;
    logic [3:0] cs_n;
    logic [7:0] edges;
    int fail_count, n_compared, cyc, seed, held, pdiv;
    int c_div[4], c_len[4], c_hold[4], c_cp[4], c_ph[4];

    spiqk_master #(.NSEL(4)) i_dut (.core_clk(core_clk), .arst_n(arst_n), .controller_role_bit(role),
        .fixed_select_mode(fmode), .fixed_select(fsel), .cfg_wr(cfg_wr), .cfg_sel(csel),
        .cfg_serial_clock_divider(div), .cfg_word_len(wlen), .cfg_cpol(cp), .cfg_clock_phase_inverse(ph),
        .cfg_cs_hold_after_transfer(hold), .tx_valid(tx_valid), .transmit_data_word(word),
        .tx_from_dma(dma), .miso(miso), .tx_ready(tx_ready), .transmit_drained_flag(drained),
        .rx_valid(rx_valid), .rx_data(rx_data), .dma_size(dma_size), .serial_clock_pin(sclk),
        .mosi(mosi), .cs_n(cs_n));
    spiqk_slave i_slave (.core_clk(core_clk), .arst_n(arst_n), .cs_n(cs_n), .serial_clock_pin(sclk),
        .mosi(mosi), .lvl(lvl), .clr(clr), .miso(miso), .first_bit(first_bit), .edges(edges));

    // Clock and hang guard
    initial
    begin
        core_clk = 0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Reference model: edge count of one word
    function automatic int exp_edges(int d, int l, int c, int p, int pd);
        return 2 * l + (((d == 1 && l % 2 == 1) || (d == 1 && c == 1 && p == 0 && pd != 1)) ? 2 : 0);
    endfunction

    task automatic cfg(input int s, input int d, input int l, input int c, input int p, input int h);
        @(negedge core_clk);
        csel <= 2'(s);
        div <= 8'(d);
        wlen <= 4'(l);
        cp <= c[0];
        ph <= p[0];
        hold <= h[0];
        cfg_wr <= 1;
        c_div[s] = d;
        c_len[s] = l;
        c_cp[s] = c;
        c_ph[s] = p;
        c_hold[s] = h;
        @(negedge core_clk);
        cfg_wr <= 0;
    endtask

    // One word through the model and the design
    task automatic send(input int s, input bit fin, input bit dm);
        int n, len, quirk, keep;
        logic [15:0] d;
        d = 16'($random(seed));
        len = 8 + c_len[s];
        quirk = c_hold[s] && c_div[s] == 1 && held == s;
        keep = c_hold[s] && !(fin && dm);
        @(negedge core_clk);
        fsel <= 2'(s);
        repeat (3) @(negedge core_clk);
        `CHK("tx_ready idle", 1, tx_ready)
        word <= {7'h00, fin, 4'h0, ~(4'h1 << s), d};
        dma <= dm;
        lvl <= d[0];
        clr <= 1;
        tx_valid <= 1;
        @(negedge core_clk);
        tx_valid <= 0;
        clr <= 0;
        n = 0;
        while (rx_valid !== 1'b1 && n < 3000)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        `CHK("rx_data", d[0] ? (1 << len) - 1 : 0, rx_data)
        `CHK("edges", exp_edges(c_div[s], len, c_cp[s], c_ph[s], pdiv), edges)
        if (held != s)
            `CHK("msb", d[len-1], first_bit)
        `CHK("drained", 1, drained)
        `CHK("cs_n", keep ? ~(4'h1 << s) : 4'hf, cs_n)
        `CHK("tx_ready", !quirk, tx_ready)
        pdiv = c_div[s];
        held = keep ? s : -1;
        if (quirk)
        begin
            n = 0;
            do
            begin
                @(posedge core_clk);
                #1;
                n++;
            end
            while (rx_valid !== 1'b1 && n < 3000);
            `CHK("resent", 1, rx_valid)
        end
    endtask

    initial
    begin
        seed = 21872;
        {arst_n, role, fmode, cfg_wr, cp, ph, hold, tx_valid, dma, lvl, clr} = '0;
        {fsel, csel, div, wlen, word} = '0;
        held = -1;
        pdiv = 1;
        for (int s = 0; s < 4; s++)
        begin
            c_div[s] = 1;
            c_len[s] = 0;
            c_hold[s] = 0;
            c_cp[s] = 0;
            c_ph[s] = 0;
        end
        repeat (20) @(negedge core_clk);
        `CHK("rst ready", 1, tx_ready)
        `CHK("rst drained", 1, drained)
        `CHK("rst cs_n", 4'hf, cs_n)
        `CHK("rst size", 0, dma_size)
        arst_n <= 1;
        // Config written before the controller role gives stray clock edges
        cfg(0, 1, 0, 0, 0, 0);
        @(negedge core_clk);
        role <= 1;
        repeat (10) @(negedge core_clk);
        `CHK("stray", 2, edges)
        // Every length, divider 1 and 2, both select modes
        for (int i = 0; i < 18; i++)
        begin
            @(negedge core_clk);
            fmode <= i[0];
            cfg(i % 4, 1 + i[0], i / 2, 0, 0, 0);
            send(i % 4, 0, 0);
            `CHK("size loop", (i[0] ? c_len[0] : c_len[i % 4]) != 0, dma_size)
        end
        // Transfer size follows select 0 in fixed mode
        fmode <= 1;
        cfg(0, 2, 2, 0, 0, 0);
        cfg(1, 2, 0, 0, 0, 0);
        fsel <= 2'h1;
        repeat (3) @(negedge core_clk);
        `CHK("size half", 1, dma_size)
        cfg(0, 2, 0, 0, 0, 0);
        repeat (3) @(negedge core_clk);
        `CHK("size byte", 0, dma_size)
        send(1, 0, 1);
        // Slow select then divider-1 select, idle-high clock
        cfg(1, 2, 0, 1, 0, 0);
        cfg(2, 1, 0, 1, 0, 0);
        send(1, 0, 0);
        send(2, 0, 0);
        // Held select released by the final flag of a DMA word
        cfg(3, 2, 0, 0, 0, 1);
        send(3, 0, 1);
        send(3, 1, 1);
        // Held select with divider 1 repeats the second word
        cfg(3, 1, 0, 0, 0, 1);
        send(3, 0, 0);
        send(3, 0, 0);
        wrap_up();
    end
endmodule

// [tb/spiqk_slave.sv]
// Behavioural serial slave that watches the bus and answers on miso
`timescale 1ns/10ps
module spiqk_slave
    import spiqk_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [SPIQK_NSEL-1:0] cs_n,
    input wire logic serial_clock_pin,
    input wire logic mosi,
    input wire logic lvl,
    input wire logic clr,
    output logic miso,
    output logic first_bit,
    output logic [7:0] edges
);
    logic sclk_q;
    logic sel_q;
    // Count serial clock changes, note the first bit of a frame, drive miso
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sclk_q <= 1'b0;
            sel_q <= 1'b0;
            edges <= 8'h00;
            first_bit <= 1'b0;
            miso <= 1'b0;
        end
        else
        begin
            sclk_q <= serial_clock_pin;
            sel_q <= ~&cs_n;
            if (clr)
                edges <= 8'h00;
            else if (serial_clock_pin != sclk_q)
                edges <= edges + 8'h01;
            if (~&cs_n && !sel_q)
                first_bit <= mosi;
            miso <= (~&cs_n) ? lvl : ~miso; // Released line flips every cycle
        end
    end
endmodule
